/* File: rtl/intc_regs.svh */
// Constants for the four-level interrupt controller
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

`define INTC_NUM_SRC      24
`define INTC_SRC_W        5
`define INTC_VEC_BASE     16'h0003
`define INTC_VEC_STEP     16'h0008
`define INTC_SRC_EXT0     5'h00
`define INTC_SRC_TIMER0   5'h01
`define INTC_SRC_EXT1     5'h02
`define INTC_SRC_TIMER1   5'h03
`define INTC_SRC_EXT2     5'h06
`define INTC_SRC_SYSFLAG  5'h0A
`define INTC_SRC_EXT3     5'h0F
`define INTC_SRC_DMA      5'h12
`define INTC_SYSFLAG_W    11
`define INTC_SYSFLAG_TX   10
`define INTC_DMA_W        3

`endif

/* File: rtl/intc_pkg.sv */
// Types shared by the interrupt controller modules
package intc_pkg;

  typedef logic [1:0] level_t;
  typedef logic [4:0] src_t;

  typedef struct packed {
    logic   valid;
    src_t   source;
    level_t level;
  } grant_s;

endpackage : intc_pkg

/* File: rtl/intc_arbiter.sv */
// Level and polling-order arbiter for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"

module intc_arbiter
  import intc_pkg::*;
(
  input  wire logic [23:0] pending,
  input  wire logic [23:0] prio_high,
  input  wire logic [23:0] prio_low,
  output var  grant_s      grant
);

  always_comb begin
    grant = '0;
    for (int i = `INTC_NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i] && (!grant.valid || {prio_high[i], prio_low[i]} >= grant.level)) begin
        grant.valid  = 1'b1;
        grant.source = src_t'(i);
        grant.level  = {prio_high[i], prio_low[i]};
      end
    end
  end

endmodule : intc_arbiter
`default_nettype wire

/* File: rtl/four_level_interrupt_controller.sv */
// Four-level, 24-source interrupt controller facing the CPU core
// Function
// - Twenty-four sources, four priority levels each
// - Request only with its own enable set
// - Nothing serviced without global enable
// - Software set/clear acts like hardware
// - Level from high bit and low bit
// - Same level: source 0 first, 23 last
// - Vector 0003H plus eight per source
// - System flag source ORs its members, transmit member only with sysflag_tx_share
// - DMA source ORs done and timers
// - External 3 own flag, enable, level
// - Each external input level or edge
// - Edge flags auto-clear; level flags follow
// - Timer 0/1 flags auto-clear on vectoring
// - Peripheral flags left for software clearing
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"

module four_level_interrupt_controller
  import intc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        global_int_enable,
  input  wire logic [23:0]                 source_enable,
  input  wire logic [23:0]                 prio_high,
  input  wire logic [23:0]                 prio_low,
  input  wire logic [3:0]                  ext_pin_n,
  input  wire logic [3:0]                  ext_trigger_type,
  input  wire logic [1:0]                  timer_overflow,
  input  wire logic [5:0]                  sw_flag_set,
  input  wire logic [5:0]                  sw_flag_clr,
  input  wire logic [23:0]                 periph_request,
  input  wire logic [`INTC_SYSFLAG_W-1:0]  sysflag_members,
  input  wire logic                        sysflag_tx_share,
  input  wire logic [`INTC_DMA_W-1:0]      dma_members,
  input  wire logic                        cpu_ack,
  input  wire logic                        cpu_reti,
  output logic                             irq_req,
  output logic [15:0]                      irq_vector,
  output logic [4:0]                       irq_source,
  output logic [1:0]                       irq_level,
  output logic [3:0]                       in_service,
  output logic [5:0]                       flag_state
);

  // Flags held here: bits 0..3 external 0..3, bits 4..5 timer 0..1
  localparam src_t FLAG_SRC [6] = '{`INTC_SRC_EXT0, `INTC_SRC_EXT1, `INTC_SRC_EXT2,
                                    `INTC_SRC_EXT3, `INTC_SRC_TIMER0, `INTC_SRC_TIMER1};

  logic [5:0]  flag_reg;
  logic [5:0]  flag_next;
  logic [3:0]  pin_reg;
  logic [3:0]  pin_next;
  logic [3:0]  svc_reg;
  logic [3:0]  svc_next;
  logic        req_reg;
  logic        req_next;
  src_t        src_reg;
  src_t        src_next;
  level_t      lvl_reg;
  level_t      lvl_next;
  logic [23:0] raw;
  logic [23:0] pending;
  grant_s      grant;
  logic        ack_hit;
  logic        preempt_ok;

  function automatic logic [1:0] top_level(input logic [3:0] mask);
    top_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (mask[l]) begin
        top_level = 2'(l);
      end
    end
  endfunction : top_level

  ////////////////////////////////////////////////////////////////////////
  // Request flags
  always_comb begin
    flag_next = flag_reg;
    pin_next  = ext_pin_n;
    for (int f = 0; f < 6; f++) begin
      // edge and timer flags cleared on vectoring
      if (ack_hit && src_reg == FLAG_SRC[f] && (f >= 4 || ext_trigger_type[f])) begin
        flag_next[f] = 1'b0;
      end
      if (sw_flag_clr[f]) begin
        flag_next[f] = 1'b0;
      end
      if (f < 4) begin
        if (ext_trigger_type[f]) begin
          if (pin_reg[f] && !ext_pin_n[f]) begin
            flag_next[f] = 1'b1;
          end
        end else begin
          flag_next[f] = !ext_pin_n[f];
        end
      end else if (timer_overflow[f-4]) begin
        // Timers have no pin history; the overflow pulse or a software set sets them
        flag_next[f] = 1'b1;
      end
      // software set wins over any clear
      if (sw_flag_set[f]) begin
        flag_next[f] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag_reg <= 6'h00;
      // Idle-high history, so leaving reset makes no false edge
      pin_reg  <= 4'hF;
    end else begin
      flag_reg <= flag_next;
      pin_reg  <= pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source gathering and arbitration
  always_comb begin
    // peripheral flags pass through, never cleared here
    raw = periph_request;
    // Held flags own their slots; the peripheral bits there are ignored
    for (int f = 0; f < 6; f++) begin
      raw[FLAG_SRC[f]] = flag_reg[f];
    end
    // system flag OR, transmit member optional
    raw[`INTC_SRC_SYSFLAG] = |sysflag_members[`INTC_SYSFLAG_TX-1:0]
                           | (sysflag_members[`INTC_SYSFLAG_TX] & sysflag_tx_share);
    raw[`INTC_SRC_DMA] = |dma_members;
    // external 3 uses its own enable bit
    pending = raw & source_enable & {24{global_int_enable}};
  end

  intc_arbiter u_arbiter (
    .pending   (pending),
    .prio_high (prio_high),
    .prio_low  (prio_low),
    .grant     (grant)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared hand-off decode
  // An ack counts only against a standing request; a stray pulse is ignored
  assign ack_hit    = cpu_ack && req_reg;
  // strictly above the highest level in service
  assign preempt_ok = (svc_reg == 4'h0) || (grant.level > top_level(svc_reg));

  ////////////////////////////////////////////////////////////////////////
  // CPU hand-off and in-service levels
  always_comb begin
    svc_next = svc_reg;
    req_next = 1'b0;
    src_next = src_reg;
    lvl_next = lvl_reg;
    if (cpu_reti && svc_reg != 4'h0) begin
      svc_next[top_level(svc_reg)] = 1'b0;
    end
    // A return blocks a new request for one cycle so the popped level settles
    if (ack_hit) begin
      svc_next[lvl_reg] = 1'b1;
    // preempt only from a strictly higher level
    end else if (grant.valid && !cpu_reti && preempt_ok) begin
      req_next = 1'b1;
      src_next = grant.source;
      lvl_next = grant.level;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      svc_reg <= 4'h0;
      req_reg <= 1'b0;
      src_reg <= 5'h00;
      lvl_reg <= 2'h0;
    end else begin
      svc_reg <= svc_next;
      req_reg <= req_next;
      src_reg <= src_next;
      lvl_reg <= lvl_next;
    end
  end

  // Vector registered with the source so it stays glitch-free for the core
  logic [15:0] vec_reg;
  logic [15:0] vec_next;

  always_comb begin
    vec_next = `INTC_VEC_BASE + (16'(src_next) * `INTC_VEC_STEP);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Same as the vector of source 0, matching the reset source
      vec_reg <= `INTC_VEC_BASE;
    end else begin
      vec_reg <= vec_next;
    end
  end

  assign irq_req    = req_reg;
  assign irq_vector = vec_reg;
  assign irq_source = src_reg;
  assign irq_level  = lvl_reg;
  assign in_service = svc_reg;
  assign flag_state = flag_reg;

endmodule : four_level_interrupt_controller
`default_nettype wire

/* File: sim/intc_sva.sv */
// Port checker for the four-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module intc_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        global_int_enable,
  input wire logic        cpu_ack,
  input wire logic        cpu_reti,
  input wire logic [5:0]  sw_flag_set,
  input wire logic [1:0]  timer_overflow,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [4:0]  irq_source,
  input wire logic [1:0]  irq_level,
  input wire logic [3:0]  in_service,
  input wire logic [5:0]  flag_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Reset itself is what this one watches, so it is never disabled
  chk_reset_clears: assert property (disable iff (1'b0) !rstn |=> !irq_req && in_service == 4'h0 && flag_state == 6'h00)
    else $error("outputs not cleared by reset");
  chk_vector_map: assert property (irq_req |-> irq_vector == 16'h0003 + {8'h00, irq_source, 3'h0})
    else $error("vector does not match source");
  chk_global_gate: assert property ($rose(irq_req) |-> $past(global_int_enable))
    else $error("request raised without global enable");
  chk_ack_drops: assert property (irq_req && cpu_ack |=> !irq_req)
    else $error("request stands after ack");
  chk_ack_serves: assert property (irq_req && cpu_ack |=> (in_service & (4'h1 << $past(irq_level))) != 4'h0)
    else $error("acked level not in service");
  chk_level_above: assert property (irq_req |-> in_service < (4'h1 << irq_level))
    else $error("request not above running level");
  chk_timer_clear: assert property (irq_req && cpu_ack && irq_source == 5'h01
    && !sw_flag_set[4] && !timer_overflow[0] |=> !flag_state[4])
    else $error("timer flag kept after vectoring");
  chk_sw_set: assert property (sw_flag_set != 6'h00 |=> (flag_state & $past(sw_flag_set)) == $past(sw_flag_set))
    else $error("software set did not land");
  chk_reti_pop: assert property (cpu_reti && in_service != 4'h0 && !(cpu_ack && irq_req)
    |=> $countones(in_service) + 1 == $countones($past(in_service)))
    else $error("return did not pop one level");
endmodule : intc_sva
bind four_level_interrupt_controller intc_sva i_sva (.clk, .rstn, .global_int_enable, .cpu_ack, .cpu_reti,
  .sw_flag_set, .timer_overflow, .irq_req, .irq_vector, .irq_source, .irq_level, .in_service, .flag_state);
`default_nettype wire

/* File: sim/cpu_core_model.sv */
// Behavioural core that takes interrupts and returns from them
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ack_en,
  input  wire logic       irq_req,
  input  wire logic [3:0] svc_len,
  output logic            cpu_ack = 1'b0,
  output logic            cpu_reti = 1'b0
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] depth = 3'h0;
  logic       take;
  logic       back;
  ////////////////////////////////////////
  // take only a standing request
  assign take = rstn && ack_en && irq_req && !cpu_ack;
  assign back = rstn && !take && depth != 3'h0 && cnt == 4'h0 && !cpu_reti;
  always @(posedge clk) begin
    cpu_ack <= #1 take;
    cpu_reti <= #1 back;
    depth <= #1 !rstn ? 3'h0 : depth + 3'(take) - 3'(back);
    cnt <= #1 (take || back) ? svc_len : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
  end
endmodule : cpu_core_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, rstn = 1'b0, global_int_enable = 1'b0, sysflag_tx_share = 1'b0, ack_en = 1'b0;
  logic [23:0] source_enable = 24'hFFFFFF, prio_high = 24'h000000, prio_low = 24'h000000, periph_request = 24'h000000;
  logic [3:0]  ext_pin_n = 4'hF, ext_trigger_type = 4'hF, svc_len = 4'h3, in_service;
  logic [1:0]  timer_overflow = 2'h0, irq_level;
  logic [5:0]  sw_flag_set = 6'h00, sw_flag_clr = 6'h00, flag_state;
  logic [10:0] sysflag_members = 11'h000;
  logic [2:0]  dma_members = 3'h0;
  logic        cpu_ack, cpu_reti, irq_req;
  logic [15:0] irq_vector;
  logic [4:0]  irq_source;
  int          error_cnt = 0, cmp_count = 0, n, t = 0;
  four_level_interrupt_controller i_dut (.clk, .rstn, .global_int_enable, .source_enable, .prio_high, .prio_low,
    .ext_pin_n, .ext_trigger_type, .timer_overflow, .sw_flag_set, .sw_flag_clr, .periph_request, .sysflag_members,
    .sysflag_tx_share, .dma_members, .cpu_ack, .cpu_reti, .irq_req, .irq_vector, .irq_source, .irq_level,
    .in_service, .flag_state);
  cpu_core_model i_cpu (.clk, .rstn, .ack_en, .irq_req, .svc_len, .cpu_ack, .cpu_reti);
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("compares=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic req(input logic [15:0] v);
    cyc(3);
    chk(16'(irq_req), 16'h0001);
    chk(irq_vector, v);
    chk(16'(irq_source), (v - 16'h0003) >> 3);
  endtask : req
  initial begin
    forever #20 clk = ~clk;
  end
  // A hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    t <= t + 1;
    if (t == 5000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end
  initial begin
    cyc(8);
    chk({5'h00, irq_req, in_service, flag_state}, 16'h0000); // RESET
    chk(irq_vector, 16'h0003); // RESET
    rstn = 1'b1;
    sw_flag_set = 6'h02;
    cyc(1);
    sw_flag_set = 6'h00;
    cyc(3);
    chk(16'(irq_req), 16'h0000);
    global_int_enable = 1'b1;
    req(16'h0013);
    sw_flag_clr = 6'h02;
    cyc(1);
    sw_flag_clr = 6'h00;
    cyc(3);
    chk(16'(irq_req), 16'h0000);
    source_enable = 24'hFFFFEF;
    periph_request = 24'h000010;
    cyc(3);
    chk(16'(irq_req), 16'h0000);
    source_enable = 24'hFFFFFF;
    req(16'h0023);
    // Held and composed sources are skipped: bits 0-3, 6, 10, 15, 18
    for (n = 0; n < 23; n++) begin
      if (!(24'h04844F >> n & 24'h000001)) begin
        periph_request = 24'h800000 | (24'h000001 << n);
        req(16'h0003 + 16'(8 * n));
      end
    end
    periph_request = 24'h800010;
    prio_low = 24'h000010;
    prio_high = 24'h800000;
    req(16'h00BB);
    chk(16'(irq_level), 16'h0002);
    prio_high = 24'h800010;
    req(16'h0023);
    chk(16'(irq_level), 16'h0003);
    periph_request = 24'h000000;
    prio_high = 24'h000000;
    prio_low = 24'h000000;
    sysflag_members = 11'h400;
    cyc(3);
    chk(16'(irq_req), 16'h0000);
    sysflag_tx_share = 1'b1;
    for (n = 0; n < 14; n++) begin
      sysflag_members = (n < 11) ? 11'h001 << n : 11'h000;
      dma_members = (n > 10) ? 3'h1 << (n - 11) : 3'h0;
      req((n < 11) ? 16'h0053 : 16'h0093);
    end
    sysflag_members = 11'h000;
    dma_members = 3'h0;
    ack_en = 1'b1;
    ext_pin_n = 4'h7;
    cyc(1);
    chk(16'(flag_state), 16'h0008);
    cyc(1);
    chk(irq_vector, 16'h007B);
    cyc(3);
    chk(16'(flag_state), 16'h0000);
    ext_pin_n = 4'hE;
    ext_trigger_type = 4'hE;
    cyc(6);
    chk(16'(flag_state), 16'h0001);
    ack_en = 1'b0;
    cyc(1);
    ext_pin_n = 4'hF;
    cyc(12);
    chk({flag_state, 6'h00, in_service}, 16'h0000);
    ack_en = 1'b1;
    timer_overflow = 2'h3;
    cyc(1);
    timer_overflow = 2'h0;
    chk(16'(flag_state), 16'h0030);
    cyc(20);
    chk(16'(flag_state), 16'h0000);
    svc_len = 4'hF;
    periph_request = 24'h000010;
    cyc(5);
    chk(16'(in_service), 16'h0001);
    prio_high = 24'h800000;
    periph_request = 24'h800010;
    cyc(5);
    chk(16'(in_service), 16'h0005);
    periph_request = 24'h000000;
    cyc(40);
    chk(16'(in_service), 16'h0000);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
